// ---- hdl/mpss_top.sv ----
// monitor pin source select with top prescaler settings
// Functional notes
// - setting 101 divides by 16 or 17
// - setting 110 divides by 32/33, default
// - select in 0x017[7:2], locked by 0x01D[7]
// - zero and unlisted low codes give low
// - codes 1-6 route divider and detector signals
// - high codes shared with other pin selectors
// - 100000 low, 100001 first reference clock
// - 100010 second reference, not differential
// - 100011 selected reference to loop
// - 100100 unselected reference, not differential
// - 100101 selected reference valid level
// - 100110 unselected valid, not differential
`timescale 1ns/10ps
module mpss_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [9:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [9:0] rd_addr,
    input wire logic [2:0] presc_setting,
    input wire logic swallow_nonzero,
    input wire logic ndiv_delayed,
    input wire logic rdiv_delayed,
    input wire logic swallow_out,
    input wire logic presc_out,
    input wire logic phase_detector_up,
    input wire logic phase_detector_down,
    input wire logic first_reference,
    input wire logic second_reference,
    input wire logic diff_ref_mode,
    input wire logic ref_select,
    input wire logic sel_ref_valid,
    input wire logic unsel_ref_valid,
    output logic [7:0] rd_data,
    output logic [5:0] presc_modulus,
    output logic monitor_pin,
    output logic [5:0] shared_code
);
    logic [7:0] sel_reg;
    logic lock_reg;
    logic [5:0] code;
    logic sel_clk;
    logic unsel_clk;
    logic mux_next;

    // select field must stay six bits, lock bit inside the byte
    localparam int SEL_SPAN = mpss_pkg::MPSS_SEL_MSB
        - mpss_pkg::MPSS_SEL_LSB + 1;
    if (SEL_SPAN != 6) begin : g_field_chk
        $error("select field must be six bits wide");
    end
    if (mpss_pkg::MPSS_LOCK_BIT > 7) begin : g_lock_chk
        $error("lock bit must sit inside the byte");
    end

    assign code = sel_reg[mpss_pkg::MPSS_SEL_MSB:mpss_pkg::MPSS_SEL_LSB];
    assign sel_clk = ref_select ? second_reference : first_reference;
    assign unsel_clk = ref_select ? first_reference : second_reference;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_reg <= mpss_pkg::MPSS_SEL_RESET;
            lock_reg <= 1'b0;
        end else if (clk_en && wr_en) begin
            if (wr_addr == mpss_pkg::MPSS_ADDR_LOCK) begin
                lock_reg <= wr_data[mpss_pkg::MPSS_LOCK_BIT];
            end else if (wr_addr == mpss_pkg::MPSS_ADDR_SEL && !lock_reg) begin
                sel_reg <= {wr_data[mpss_pkg::MPSS_SEL_MSB:
                    mpss_pkg::MPSS_SEL_LSB], 2'b00};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (clk_en) begin
            if (rd_addr == mpss_pkg::MPSS_ADDR_SEL) begin
                rd_data <= sel_reg;
            end else if (rd_addr == mpss_pkg::MPSS_ADDR_LOCK) begin
                rd_data <= {lock_reg, 7'h00};
            end else begin
                rd_data <= 8'h00;
            end
        end
    end

    // modulus base; plus one applies during swallow phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presc_modulus <= mpss_pkg::MPSS_BASE_32;
        end else if (clk_en) begin
            if (presc_setting == mpss_pkg::MPSS_PRESC_16) begin
                presc_modulus <= mpss_pkg::MPSS_BASE_16
                    + {5'h00, swallow_nonzero};
            end else if (presc_setting == mpss_pkg::MPSS_PRESC_32) begin
                presc_modulus <= mpss_pkg::MPSS_BASE_32
                    + {5'h00, swallow_nonzero};
            end else begin
                presc_modulus <= 6'h00;
            end
        end
    end

    always_comb begin
        case (code)
            mpss_pkg::MPSS_CODE_NDIV: mux_next = ndiv_delayed;
            mpss_pkg::MPSS_CODE_RDIV: mux_next = rdiv_delayed;
            mpss_pkg::MPSS_CODE_SWAL: mux_next = swallow_out;
            mpss_pkg::MPSS_CODE_PRESC: mux_next = presc_out;
            mpss_pkg::MPSS_CODE_UP: mux_next = phase_detector_up;
            mpss_pkg::MPSS_CODE_DOWN: mux_next = phase_detector_down;
            mpss_pkg::MPSS_CODE_HGND: mux_next = 1'b0;
            mpss_pkg::MPSS_CODE_FIRST: mux_next = first_reference;
            mpss_pkg::MPSS_CODE_SECOND:
                mux_next = !diff_ref_mode && second_reference;
            mpss_pkg::MPSS_CODE_SELREF:
                mux_next = diff_ref_mode ? first_reference : sel_clk;
            mpss_pkg::MPSS_CODE_UNSREF:
                mux_next = !diff_ref_mode && unsel_clk;
            mpss_pkg::MPSS_CODE_SELOK: mux_next = sel_ref_valid;
            mpss_pkg::MPSS_CODE_UNSOK:
                mux_next = !diff_ref_mode && unsel_ref_valid;
            default: mux_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            monitor_pin <= 1'b0;
            shared_code <= 6'h00;
        end else if (clk_en) begin
            monitor_pin <= mux_next;
            shared_code <= code[5] ? code : 6'h00;
        end
    end

    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // unlocked write to the select field
    sequence s_sel_write;
        clk_en && wr_en && wr_addr == mpss_pkg::MPSS_ADDR_SEL && !lock_reg;
    endsequence
    sequence s_lock_write;
        clk_en && wr_en && wr_addr == mpss_pkg::MPSS_ADDR_LOCK;
    endsequence
    // first reference chosen, then one enabled cycle
    sequence s_first_select;
        s_sel_write ##0 (wr_data & 8'hfc) == {mpss_pkg::MPSS_CODE_FIRST,
            2'b00} ##1 clk_en;
    endsequence

    a_low_default: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_GND |=> !monitor_pin)
        else $error("ground code not low");
    a_low_unlisted: assert property (
        clk_en && !code[5] && code > mpss_pkg::MPSS_CODE_DOWN
        |=> !monitor_pin)
        else $error("unlisted low code not low");
    a_ndiv_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_NDIV
        |=> monitor_pin == $past(ndiv_delayed))
        else $error("n divider not routed");
    a_rdiv_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_RDIV
        |=> monitor_pin == $past(rdiv_delayed))
        else $error("r divider not routed");
    a_swal_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_SWAL
        |=> monitor_pin == $past(swallow_out))
        else $error("swallow counter not routed");
    a_presc_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_PRESC
        |=> monitor_pin == $past(presc_out))
        else $error("prescaler output not routed");
    a_up_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_UP
        |=> monitor_pin == $past(phase_detector_up))
        else $error("up pulse not routed");
    a_down_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_DOWN
        |=> monitor_pin == $past(phase_detector_down))
        else $error("down pulse not routed");
    a_high_ground: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_HGND |=> !monitor_pin)
        else $error("high ground code not low");
    a_first_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_FIRST
        |=> monitor_pin == $past(first_reference))
        else $error("first reference not routed");
    a_second_route: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_SECOND && !diff_ref_mode
        |=> monitor_pin == $past(second_reference))
        else $error("second reference not routed");
    a_second_diff: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_SECOND && diff_ref_mode
        |=> !monitor_pin)
        else $error("second reference in differential");
    a_selref_first: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_SELREF
        && (diff_ref_mode || !ref_select)
        |=> monitor_pin == $past(first_reference))
        else $error("selected first reference not routed");
    a_selref_second: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_SELREF
        && !diff_ref_mode && ref_select
        |=> monitor_pin == $past(second_reference))
        else $error("selected second reference not routed");
    a_unsref_first: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_UNSREF
        && !diff_ref_mode && ref_select
        |=> monitor_pin == $past(first_reference))
        else $error("unselected first reference not routed");
    a_unsref_second: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_UNSREF
        && !diff_ref_mode && !ref_select
        |=> monitor_pin == $past(second_reference))
        else $error("unselected second reference not routed");
    a_sel_valid: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_SELOK
        |=> monitor_pin == $past(sel_ref_valid))
        else $error("valid level wrong");
    a_unsel_valid: assert property (
        clk_en && code == mpss_pkg::MPSS_CODE_UNSOK && !diff_ref_mode
        |=> monitor_pin == $past(unsel_ref_valid))
        else $error("unselected valid level wrong");
    a_unsel_diff: assert property (
        clk_en && diff_ref_mode && (code == mpss_pkg::MPSS_CODE_UNSOK
        || code == mpss_pkg::MPSS_CODE_UNSREF) |=> !monitor_pin)
        else $error("unselected in differential");
    a_shared_high: assert property (
        clk_en && code[5] |=> shared_code == $past(code))
        else $error("shared code not passed on");
    a_shared_low: assert property (
        clk_en && !code[5] |=> shared_code == 6'h00)
        else $error("shared code not cleared");
    a_sel_write: assert property (
        s_sel_write |=> sel_reg == ($past(wr_data) & 8'hfc))
        else $error("select write lost");
    a_lock_write: assert property (
        s_lock_write |=> {lock_reg, 7'h00} == ($past(wr_data) & 8'h80))
        else $error("lock write lost");
    a_lock_holds: assert property (
        lock_reg |=> $stable(sel_reg))
        else $error("select changed while locked");
    a_first_follow: assert property (
        s_first_select |=> monitor_pin == $past(first_reference))
        else $error("pin did not follow new select");
    a_presc_32: assert property (
        clk_en && presc_setting == mpss_pkg::MPSS_PRESC_32
        |=> presc_modulus == ($past(swallow_nonzero)
        ? mpss_pkg::MPSS_BASE_32 + 6'h01 : mpss_pkg::MPSS_BASE_32))
        else $error("modulus 32 wrong");
    a_presc_16: assert property (
        clk_en && presc_setting == mpss_pkg::MPSS_PRESC_16
        |=> presc_modulus == ($past(swallow_nonzero)
        ? mpss_pkg::MPSS_BASE_16 + 6'h01 : mpss_pkg::MPSS_BASE_16))
        else $error("modulus 16 wrong");
    // a low enable freezes every register
    a_freeze_hold: assert property (
        !clk_en |=> $stable(sel_reg) && $stable(lock_reg)
        && $stable(rd_data) && $stable(presc_modulus)
        && $stable(monitor_pin) && $stable(shared_code))
        else $error("state moved while disabled");
endmodule // mpss_top

// ---- hdl/mpss_pkg.sv ----
// constants for the monitor pin signal select block
package mpss_pkg;
    localparam logic [9:0] MPSS_ADDR_SEL = 10'h017;
    localparam logic [9:0] MPSS_ADDR_LOCK = 10'h01D;
    localparam int MPSS_SEL_LSB = 2;
    localparam int MPSS_SEL_MSB = 7;
    localparam int MPSS_LOCK_BIT = 7;
    localparam logic [7:0] MPSS_SEL_RESET = 8'h00;
    localparam logic [2:0] MPSS_PRESC_RESET = 3'h6;
    localparam logic [2:0] MPSS_PRESC_16 = 3'h5;
    localparam logic [2:0] MPSS_PRESC_32 = 3'h6;
    localparam logic [5:0] MPSS_BASE_16 = 6'h10;
    localparam logic [5:0] MPSS_BASE_32 = 6'h20;
    localparam logic [5:0] MPSS_CODE_GND = 6'h00;
    localparam logic [5:0] MPSS_CODE_NDIV = 6'h01;
    localparam logic [5:0] MPSS_CODE_RDIV = 6'h02;
    localparam logic [5:0] MPSS_CODE_SWAL = 6'h03;
    localparam logic [5:0] MPSS_CODE_PRESC = 6'h04;
    localparam logic [5:0] MPSS_CODE_UP = 6'h05;
    localparam logic [5:0] MPSS_CODE_DOWN = 6'h06;
    localparam logic [5:0] MPSS_CODE_HGND = 6'h20;
    localparam logic [5:0] MPSS_CODE_FIRST = 6'h21;
    localparam logic [5:0] MPSS_CODE_SECOND = 6'h22;
    localparam logic [5:0] MPSS_CODE_SELREF = 6'h23;
    localparam logic [5:0] MPSS_CODE_UNSREF = 6'h24;
    localparam logic [5:0] MPSS_CODE_SELOK = 6'h25;
    localparam logic [5:0] MPSS_CODE_UNSOK = 6'h26;
endpackage

// ---- bench/mpss_top_bench.sv ----
// self-checking bench for the monitor pin source select
`timescale 1ns/10ps
module mpss_top_bench;
    logic clk_sys = 0;
    logic rst = 1;
    logic clk_en = 1;
    logic wr_en = 0;
    logic [9:0] wr_addr = 10'h000;
    logic [7:0] wr_data = 8'h00;
    logic [9:0] rd_addr = 10'h017;
    logic [2:0] presc_setting = 3'h0;
    logic swallow_nonzero = 0;
    logic [9:0] src = 10'h000;
    logic diff_ref_mode = 0;
    logic ref_select = 0;
    logic [7:0] rd_data;
    logic [5:0] presc_modulus;
    logic monitor_pin;
    logic [5:0] shared_code;
    logic [11:0] r;
    logic [7:0] e;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    // code, differential, reference choice, source index (f: none)
    localparam logic [11:0] ROWS [23] = '{12'h040, 12'h081, 12'h0c2,
        12'h103, 12'h144, 12'h185, 12'h00f, 12'h1cf, 12'h80f, 12'h846,
        12'h866, 12'h887, 12'h8af, 12'h8c6, 12'h8d7, 12'h8f6, 12'h907,
        12'h916, 12'h92f, 12'h948, 12'h968, 12'h9af, 12'h989};
    always #4 clk_sys = ~clk_sys;
    mpss_top mpss_top_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .presc_setting(presc_setting),
        .swallow_nonzero(swallow_nonzero), .ndiv_delayed(src[0]),
        .rdiv_delayed(src[1]), .swallow_out(src[2]), .presc_out(src[3]),
        .phase_detector_up(src[4]), .phase_detector_down(src[5]),
        .first_reference(src[6]), .second_reference(src[7]),
        .diff_ref_mode(diff_ref_mode), .ref_select(ref_select),
        .sel_ref_valid(src[8]), .unsel_ref_valid(src[9]),
        .rd_data(rd_data), .presc_modulus(presc_modulus),
        .monitor_pin(monitor_pin), .shared_code(shared_code));
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(negedge clk_sys);
        wr_en = 1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk_sys);
        wr_en = 0;
    endtask
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        chk("modulus", {2'b00, presc_modulus}, 8'h20);
        chk("pin", {7'h00, monitor_pin}, 8'h00);
        repeat (3) @(negedge clk_sys);
        rst = 0;
        for (int i = 0; i < 23; i++) begin
            r = ROWS[i];
            diff_ref_mode = r[5];
            ref_select = r[4];
            wr(10'h017, {r[11:6], 2'b11});
            for (int p = 0; p < 2; p++) begin
                src = (r[3:0] == 4'hf) ? {10{p[0]}} :
                    (10'h001 << r[3:0]) ^ {10{p[0]}};
                repeat (2) @(negedge clk_sys);
                e = {7'h00, r[3:0] != 4'hf && p == 0};
                chk("pin", {7'h00, monitor_pin}, e);
            end
            chk("readback", rd_data, {r[11:6], 2'b00});
            e = r[11] ? {2'b00, r[11:6]} : 8'h00;
            chk("shared", {2'b00, shared_code}, e);
        end
        $display("selection rows done");
        for (int s = 0; s < 16; s++) begin
            presc_setting = s[3:1];
            swallow_nonzero = s[0];
            repeat (2) @(negedge clk_sys);
            e = s[3:1] == 3'h5 ? 8'h10 : (s[3:1] == 3'h6 ? 8'h20 : 8'h00);
            e = e + {7'h00, e != 8'h00 && s[0]};
            chk("modulus", {2'b00, presc_modulus}, e);
        end
        $display("prescaler done");
        wr(10'h01d, 8'h80);
        wr(10'h017, 8'h84);
        @(negedge clk_sys);
        chk("locked", rd_data, 8'h98);
        wr(10'h01d, 8'h00);
        clk_en = 0;
        wr(10'h017, 8'h84);
        clk_en = 1;
        @(negedge clk_sys);
        chk("held", rd_data, 8'h98);
        wr(10'h017, 8'h84);
        repeat (2) @(negedge clk_sys);
        chk("unlocked", rd_data, 8'h84);
        src = 10'h040;
        repeat (2) @(negedge clk_sys);
        chk("follow", {7'h00, monitor_pin}, 8'h01);
        clk_en = 0;
        src = 10'h000;
        repeat (2) @(negedge clk_sys);
        chk("frozen", {7'h00, monitor_pin}, 8'h01);
        clk_en = 1;
        repeat (2) @(negedge clk_sys);
        chk("resumed", {7'h00, monitor_pin}, 8'h00);
        rd_addr = 10'h3ff;
        repeat (2) @(negedge clk_sys);
        chk("unmapped", rd_data, 8'h00);
        rd_addr = 10'h017;
        src = 10'h3ff;
        rst = 1;
        @(negedge clk_sys);
        rst = 0;
        repeat (2) @(negedge clk_sys);
        chk("reset select", rd_data, 8'h00);
        chk("reset pin", {7'h00, monitor_pin}, 8'h00);
        $display("lock and reset done");
        end_of_test();
    end
endmodule // mpss_top_bench
